// [hw/jtag_tap_pll_access.sv]
// Boundary-scan test access port with chip-tap relay and PLL write path.
// Assumes TCK, TMS and TDI are asynchronous pins sampled by ref_clk.
// Function
// RULE1: One standard test access port providing boundary scan of all pins.
// RULE2: Instruction register four bits, selected data register thirty-two bits.
// RULE3: A second chip-level tap reaches the tile for loading and debug.
// RULE4: Five consecutive TMS-high rising TCK edges return the port to reset.
// RULE5: Identity instruction selects read-only identity word, bit zero is one.
// RULE6: User code instruction selects user identifier over silicon revision.
// RULE7: User identifier is low fourteen bits of user memory word.
// RULE8: User identifier loaded by boot code only, invalid while held in reset.
// RULE9: With instruction eight, shifted data goes into the PLL settings.
// RULE10: PLL settings hold a device reset bit and port boot-select bit.
// RULE11: Host gives at least one hundred TCK cycles after a PLL write.
// RULE12: User identifier occupies bits 31 down to 18 of user code.
// RULE13: Security bit zero blocks all tile access through the port.
// RULE14: Security bit four ignores PLL settings writes through the port.
// RULE15: Standard sixteen-state controller, sample on rise, TDO on fall.
// RULE16: Identity word: version 31-28, part 27-12, maker 11-1.
module jtag_tap_pll_access #(
  parameter int BSR_W = 32,
  parameter logic [3:0] ID_VERSION = 4'h0,
  // Arbitrary neutral identity values
  parameter logic [15:0] ID_PART = 16'h0123,
  parameter logic [10:0] ID_MAKER = 11'h055,
  parameter logic [17:0] SILICON_REV = 18'h0_0001
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [BSR_W-1:0] pin_sample,
  output logic [BSR_W-1:0] pin_drive,
  output logic extest_en,
  output logic chip_tck,
  output logic chip_tms,
  output logic chip_tdi,
  input wire logic chip_tdo,
  input wire logic [31:0] security_config,
  input wire logic device_in_reset,
  input wire logic user_id_load,
  input wire logic [31:0] otp_user_word,
  output logic [31:0] pll_settings,
  output logic pll_write,
  output logic device_reset_req,
  output logic boot_from_port
);

  logic [1:0] rst_q;
  logic rst_n_q;
  tap_pkg::port_pins_t pins;
  logic tck_prev_q;
  logic rise, fall;
  logic tile_lock, pll_write_lockout;

  tap_pkg::tap_state_t state_q, state_d;
  logic [tap_pkg::IR_W-1:0] ir_q, ir_d, irs_q, irs_d;
  logic [tap_pkg::DR_W-1:0] dr_q, dr_d;
  logic [BSR_W-1:0] bsr_q, bsr_d, drive_q, drive_d;
  logic [31:0] pll_q, pll_d;
  logic pll_wr_q, pll_wr_d;
  logic tdo_q, tdo_d, oe_q, oe_d;
  logic [tap_pkg::UID_W-1:0] uid_q, uid_d;
  logic [2:0] chip_q, chip_d;
  logic [31:0] device_identification_word, usercode;
  logic chip_sel;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n_q = rst_q[1];

  pin_filter #(
    .W(3)
  ) u_pins (
    .clk(ref_clk),
    .rst_n(rst_n_q),
    .raw({tck, tms, tdi}),
    .level(pins)
  );

  assign rise = pins.tck & ~tck_prev_q;
  assign fall = ~pins.tck & tck_prev_q;
  assign tile_lock = security_config[tap_pkg::SEC_TILE_LOCK_BIT];
  assign pll_write_lockout = security_config[tap_pkg::SEC_PLL_LOCK_BIT];
  assign chip_sel = (ir_q == tap_pkg::OP_CHIP_TAP) && !tile_lock; // RULE13

  assign device_identification_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1}; // RULE5 RULE16
  assign usercode = {uid_q, SILICON_REV}; // RULE6 RULE12

  // Controller state transitions on sampled TCK rise
  always_comb begin
    state_d = state_q;
    if (rise) begin
      case (state_q) // RULE15
        tap_pkg::ST_RESET:
          state_d = pins.tms ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE; // RULE4
        tap_pkg::ST_IDLE:
          state_d = pins.tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
        tap_pkg::ST_SEL_DR:
          state_d = pins.tms ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
        tap_pkg::ST_CAP_DR:
          state_d = pins.tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
        tap_pkg::ST_SHIFT_DR:
          state_d = pins.tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
        tap_pkg::ST_EXIT1_DR:
          state_d = pins.tms ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAUSE_DR;
        tap_pkg::ST_PAUSE_DR:
          state_d = pins.tms ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
        tap_pkg::ST_EXIT2_DR:
          state_d = pins.tms ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SHIFT_DR;
        tap_pkg::ST_UPD_DR:
          state_d = pins.tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
        tap_pkg::ST_SEL_IR:
          state_d = pins.tms ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR; // RULE4
        tap_pkg::ST_CAP_IR:
          state_d = pins.tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
        tap_pkg::ST_SHIFT_IR:
          state_d = pins.tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
        tap_pkg::ST_EXIT1_IR:
          state_d = pins.tms ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAUSE_IR;
        tap_pkg::ST_PAUSE_IR:
          state_d = pins.tms ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
        tap_pkg::ST_EXIT2_IR:
          state_d = pins.tms ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SHIFT_IR;
        tap_pkg::ST_UPD_IR:
          state_d = pins.tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
        default:
          state_d = tap_pkg::ST_RESET;
      endcase
    end
  end

  // Shift, capture and update paths
  always_comb begin
    ir_d = ir_q;
    irs_d = irs_q;
    dr_d = dr_q;
    bsr_d = bsr_q;
    drive_d = drive_q;
    pll_d = pll_q;
    pll_wr_d = 1'b0;
    if (rise) begin
      case (state_q)
        tap_pkg::ST_RESET:
          ir_d = tap_pkg::IR_RESET;
        tap_pkg::ST_CAP_IR:
          irs_d = tap_pkg::IR_CAPTURE;
        tap_pkg::ST_SHIFT_IR:
          irs_d = {pins.tdi, irs_q[tap_pkg::IR_W-1:1]}; // RULE2
        tap_pkg::ST_UPD_IR:
          ir_d = irs_q;
        tap_pkg::ST_CAP_DR: begin
          if (ir_q == tap_pkg::OP_DEVICE_IDENTIFICATION_WORD) begin
            dr_d = device_identification_word; // RULE5
          end else if (ir_q == tap_pkg::OP_USERCODE) begin
            dr_d = usercode; // RULE6
          end else if (ir_q == tap_pkg::OP_BYPASS) begin
            dr_d = '0;
          end else if (ir_q == tap_pkg::OP_EXTEST ||
                       ir_q == tap_pkg::OP_SAMPLE) begin
            bsr_d = pin_sample; // RULE1
          end
        end
        tap_pkg::ST_SHIFT_DR: begin
          if (ir_q == tap_pkg::OP_BYPASS) begin
            dr_d[0] = pins.tdi;
          end else if (ir_q == tap_pkg::OP_EXTEST ||
                       ir_q == tap_pkg::OP_SAMPLE) begin
            bsr_d = {pins.tdi, bsr_q[BSR_W-1:1]}; // RULE1
          end else if (!chip_sel) begin
            dr_d = {pins.tdi, dr_q[tap_pkg::DR_W-1:1]}; // RULE2
          end
        end
        tap_pkg::ST_UPD_DR: begin
          if (ir_q == tap_pkg::OP_PLL_WRITE && !pll_write_lockout) begin
            pll_d = dr_q; // RULE9 RULE14
            pll_wr_d = 1'b1;
          end else if (ir_q == tap_pkg::OP_EXTEST) begin
            drive_d = bsr_q; // RULE1
          end
        end
        default: begin
        end
      endcase
    end
  end

  // TDO changes only on falling TCK, enabled while shifting
  always_comb begin
    tdo_d = tdo_q;
    oe_d = oe_q;
    if (fall) begin
      oe_d = (state_q == tap_pkg::ST_SHIFT_DR) ||
             (state_q == tap_pkg::ST_SHIFT_IR);
      if (state_q == tap_pkg::ST_SHIFT_IR) begin
        tdo_d = irs_q[0];
      end else if (chip_sel) begin
        tdo_d = chip_tdo; // RULE3
      end else if (ir_q == tap_pkg::OP_EXTEST ||
                   ir_q == tap_pkg::OP_SAMPLE) begin
        tdo_d = bsr_q[0];
      end else begin
        tdo_d = dr_q[0]; // RULE15
      end
    end
  end

  // Chip tap relay; held idle when tile access is locked out
  always_comb begin
    chip_d = {1'b0, 1'b1, 1'b0};
    if (chip_sel) begin
      chip_d = {pins.tck, pins.tms, pins.tdi}; // RULE3 RULE13
    end
  end

  // User identifier: cleared in reset, set by boot code
  always_comb begin
    uid_d = uid_q;
    if (device_in_reset) begin
      uid_d = '0; // RULE8
    end else if (user_id_load) begin
      uid_d = otp_user_word[tap_pkg::UID_W-1:0]; // RULE7 RULE8
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tck_prev_q <= 1'b0;
      state_q <= tap_pkg::ST_RESET;
      ir_q <= tap_pkg::IR_RESET;
      irs_q <= '0;
      dr_q <= '0;
      bsr_q <= '0;
      drive_q <= '0;
      pll_q <= tap_pkg::PLL_RESET_VAL;
      pll_wr_q <= 1'b0;
      tdo_q <= 1'b0;
      oe_q <= 1'b0;
      uid_q <= '0;
      chip_q <= 3'b010;
    end else begin
      tck_prev_q <= pins.tck;
      state_q <= state_d;
      ir_q <= ir_d;
      irs_q <= irs_d;
      dr_q <= dr_d;
      bsr_q <= bsr_d;
      drive_q <= drive_d;
      pll_q <= pll_d;
      pll_wr_q <= pll_wr_d;
      tdo_q <= tdo_d;
      oe_q <= oe_d;
      uid_q <= uid_d;
      chip_q <= chip_d;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = oe_q;
  assign pin_drive = drive_q;
  assign extest_en = (ir_q == tap_pkg::OP_EXTEST);
  assign {chip_tck, chip_tms, chip_tdi} = chip_q;
  // Committed within ref_clk; no trailing TCK needed here
  assign pll_settings = pll_q; // RULE11
  assign pll_write = pll_wr_q;
  assign device_reset_req = pll_q[tap_pkg::PLL_DEV_RESET_BIT]; // RULE10
  assign boot_from_port = pll_q[tap_pkg::PLL_BOOT_PORT_BIT]; // RULE10

endmodule

// [hw/tap_pkg.sv]
// Constants and carrier types for the boundary-scan test access port.
// Assumes one system clock that samples all port pins.
package tap_pkg;

  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam int UID_W = 14;
  localparam int UID_LSB = 18;
  localparam int REV_W = 18;

  // Instruction codes
  localparam logic [3:0] OP_EXTEST = 4'h0;
  localparam logic [3:0] OP_DEVICE_IDENTIFICATION_WORD = 4'h1;
  localparam logic [3:0] OP_SAMPLE = 4'h2;
  localparam logic [3:0] OP_USERCODE = 4'h3;
  localparam logic [3:0] OP_CHIP_TAP = 4'h4;
  localparam logic [3:0] OP_PLL_WRITE = 4'h8;
  localparam logic [3:0] OP_BYPASS = 4'hF;

  // Reset and capture values
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_RESET = OP_DEVICE_IDENTIFICATION_WORD;
  localparam logic [31:0] PLL_RESET_VAL = 32'h0000_0000;

  // Field positions
  localparam int PLL_DEV_RESET_BIT = 31;
  localparam int PLL_BOOT_PORT_BIT = 30;
  localparam int SEC_TILE_LOCK_BIT = 0;
  localparam int SEC_PLL_LOCK_BIT = 4;

  // Sampled port pins travel together
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } port_pins_t;

  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SHIFT_DR = 16'h0010,
    ST_EXIT1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EXIT2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EXIT2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } tap_state_t;

endpackage

// [hw/pin_filter.sv]
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the reset input is already synchronous to clk.
module pin_filter #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] level
);

  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [W-1:0] lvl_d;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // Stage one feeds stage two only
      always_comb begin
        lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;

endmodule

// [sim/jtag_tap_pll_access_assertions.sv]
// Concurrent checks on the test port outputs, bound to the top module.
// Assumes ref_clk samples every signal and reset_n is the raw port reset.
module jtag_tap_pll_access_checker #(
  parameter int BSR_W = 32
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic tdo_oe,
  input wire logic [BSR_W-1:0] pin_drive,
  input wire logic extest_en,
  input wire logic chip_tck,
  input wire logic chip_tms,
  input wire logic chip_tdi,
  input wire logic [31:0] security_config,
  input wire logic [31:0] pll_settings,
  input wire logic pll_write,
  input wire logic device_reset_req,
  input wire logic boot_from_port
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  chk_pll_pulse: assert property (pll_write |=> !pll_write)
    else $error("pll_write wider than one cycle");
  chk_pll_only_on_write: assert property (
    $changed(pll_settings) |-> pll_write)
    else $error("pll_settings changed without write");
  chk_pll_lockout: assert property (
    security_config[4] && $past(security_config[4]) |-> !pll_write)
    else $error("pll write while locked out");
  chk_reset_bit: assert property (
    pll_write |=> device_reset_req == pll_settings[31])
    else $error("device_reset_req wrong");
  chk_boot_bit: assert property (
    pll_write |=> boot_from_port == pll_settings[30])
    else $error("boot_from_port wrong");
  chk_write_mode: assert property (
    pll_write |-> !tdo_oe && !extest_en)
    else $error("pll write outside update");
  chk_pin_update: assert property (
    $changed(pin_drive) |-> extest_en && !tdo_oe)
    else $error("pin_drive changed outside extest update");
  chk_relay_idle: assert property (
    security_config[0] ##1 security_config[0]
    |-> !chip_tck && chip_tms && !chip_tdi)
    else $error("chip relay active while locked");
  chk_relay_gate: assert property (
    $rose(chip_tck) |-> !$past(security_config[0]))
    else $error("chip clock rose while locked");
  cover property (pll_write);
  cover property ($rose(chip_tck));
  cover property ($changed(pin_drive));
endmodule

// [sim/jtag_host_model.sv]
// Test host model; TCK stands low between frames.
// Assumes ref_clk at 20 ns; one TCK period is eight ref_clk cycles.
module jtag_host_model (
  input wire logic ref_clk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Long hold after the rise covers the pin filter delay
  task automatic tick(input logic m, input logic d, output logic o);
    w(2);
    tms = m;
    tdi = d;
    w(2);
    tck = 1'h1;
    w(4);
    o = tdo;
    tck = 1'h0;
  endtask
  task automatic reset();
    logic o;
    for (int i = 0; i < 6; i++) tick(i < 5, 1'h0, o);
  endtask
  task automatic idle(input int n);
    logic o;
    repeat (n) tick(1'h0, 1'h0, o);
  endtask
  // Idle to Idle through one shift, LSB first
  task automatic scan(input logic is_ir, input int n,
      input logic [31:0] din, output logic [31:0] dout);
    logic o;
    dout = 32'h0;
    tick(1'h1, 1'h0, o);
    if (is_ir) tick(1'h1, 1'h0, o);
    tick(1'h0, 1'h0, o);
    tick(1'h0, 1'h0, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'h1, 1'h0, o);
    tick(1'h0, 1'h0, o);
    // Last rise lands one edge after the tick returns
    w(2);
  endtask
endmodule

// [sim/test_jtag_tap_pll_access.sv]
// Bench top: host model, design and checker on one system clock.
// Assumes the host model paces TCK itself from ref_clk.
module test_jtag_tap_pll_access;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] PINS = 32'h5a5a_0f0f;
  // Arbitrary identity values
  localparam logic [17:0] REV = 18'h0_0003;
  localparam logic [31:0] ID = {4'h2, 16'h0abc, 11'h07e, 1'h1};
  logic ref_clk, reset_n, tck, tms, tdi, tdo, tdo_oe, extest_en;
  logic chip_tck, chip_tms, chip_tdi, chip_tdo, user_id_load;
  logic device_in_reset, pll_write, device_reset_req, boot_from_port;
  logic [31:0] pin_drive, security_config, otp_user_word, pll_settings, v;
  int err_count = 0;
  int tests_run = 0;
  // Loopback stands in for the chip-level tap
  assign chip_tdo = chip_tdi;
  jtag_host_model u_host (.ref_clk, .tdo, .tck, .tms, .tdi);
  jtag_tap_pll_access #(.ID_VERSION(4'h2), .ID_PART(16'h0abc),
    .ID_MAKER(11'h07e), .SILICON_REV(REV)) u_dut (
    .ref_clk, .reset_n, .tck, .tms, .tdi, .tdo, .tdo_oe,
    .pin_sample(PINS), .pin_drive, .extest_en, .chip_tck, .chip_tms,
    .chip_tdi, .chip_tdo, .security_config, .device_in_reset,
    .user_id_load, .otp_user_word, .pll_settings, .pll_write,
    .device_reset_req, .boot_from_port);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("Counts: tests=%0d errors=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic ir(input logic [3:0] op);
    u_host.scan(1'h1, 4, {28'h0, op}, v);
    check(v[3:0], tap_pkg::IR_CAPTURE);
  endtask
  task automatic dr(input logic [31:0] d);
    u_host.scan(1'h0, 32, d, v);
  endtask
  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    finish_test();
  end
  initial begin
    reset_n = 1'h0;
    security_config = 32'h0;
    device_in_reset = 1'h1;
    user_id_load = 1'h0;
    otp_user_word = 32'hffff_fa5c;
    w(5);
    reset_n = 1'h1;
    w(10);
    check(pll_settings, 32'h0);
    check({tdo_oe, extest_en, chip_tms}, 3'h1);
    u_host.reset();
    dr(32'h0);
    check(v, ID);
    ir(tap_pkg::OP_USERCODE);
    dr(32'h0);
    check(v, {14'h0, REV});
    device_in_reset = 1'h0;
    user_id_load = 1'h1;
    w(1);
    user_id_load = 1'h0;
    dr(32'h0);
    check(v, {14'h3a5c, REV});
    u_host.reset();
    dr(32'h0);
    check(v, ID);
    ir(tap_pkg::OP_BYPASS);
    dr(32'h1);
    check(v, 32'h2);
    ir(tap_pkg::OP_SAMPLE);
    dr(32'h0);
    check(v, PINS);
    ir(tap_pkg::OP_EXTEST);
    check(extest_en, 1'h1);
    dr(32'h1234_5678);
    check(pin_drive, 32'h1234_5678);
    ir(tap_pkg::OP_PLL_WRITE);
    dr(32'hc000_1234);
    u_host.idle(100);
    check(pll_settings, 32'hc000_1234);
    check({device_reset_req, boot_from_port}, 2'h3);
    security_config = 32'h10;
    dr(32'h0);
    check(pll_settings, 32'hc000_1234);
    ir(tap_pkg::OP_CHIP_TAP);
    w(2);
    check(chip_tms, 1'h0);
    // Relay loopback returns each bit one TCK late
    dr(32'h0000_00a5);
    check(v, 32'h0000_014a);
    security_config = 32'h11;
    w(3);
    check(chip_tms, 1'h1);
    finish_test();
  end
endmodule
bind jtag_tap_pll_access jtag_tap_pll_access_checker #(.BSR_W(BSR_W)) u_chk (
  .ref_clk, .reset_n, .tdo_oe, .pin_drive, .extest_en, .chip_tck,
  .chip_tms, .chip_tdi, .security_config, .pll_settings, .pll_write,
  .device_reset_req, .boot_from_port);
